/* src/hcif_consts.svh */
`ifndef HCIF_CONSTS_SVH
`define HCIF_CONSTS_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define HCIF_CMD_FLAGS_RD   8'h24
`define HCIF_CMD_FLAGS_WR   8'hA4
`define HCIF_CMD_ENABLES_RD 8'h25
`define HCIF_CMD_ENABLES_WR 8'hA5

// ----------------------------------------------------------------------
// Flag and enable bit positions
// ----------------------------------------------------------------------
`define HCIF_BIT_SOF        0
`define HCIF_BIT_ISO_ZERO   1
`define HCIF_BIT_ISO_ONE    2
`define HCIF_BIT_XFER_DONE  3
`define HCIF_BIT_OPR        4
`define HCIF_BIT_SUSPENDED  5
`define HCIF_BIT_CLK_READY  6
`define HCIF_BIT_INTL       7
`define HCIF_BIT_ATL        8
`define HCIF_BIT_OTG        9

// ----------------------------------------------------------------------
// Suspend request field in the host control register
// ----------------------------------------------------------------------
`define HCIF_SUSP_REQ       2'h3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define HCIF_FLAGS_RST      10'h000
`define HCIF_ENABLES_RST    10'h000
`define HCIF_RDATA_RST      16'h0000

`endif

/* src/hcif_irq_flags.sv */
`timescale 1ns/1ns
`include "hcif_consts.svh"
// Contract
// - Suspended flag rises once controller enters suspend, requested by control bits 6 and 7.
// - No start-of-frame packets are issued while suspended.
// - Operational host event sets flag bit 4; driver reads cause register.
// - Transfer count zero or end-of-transfer input sets flag bit 3.
// - Last descriptor of iso buffer one done sets flag bit 2.
// - Last descriptor of iso buffer zero done sets flag bit 1.
// - Entering start-of-frame state sets flag bit 0.
// - Flag register read with code 24h, written with code A4h.
// - Enable register read with code 25h, written with code A5h.
// - Enable bits 9:0 gate flag bits 9:0 one to one.
// - Global enable input combines with per-bit enables for the interrupt output.
// - All enables cleared at power-on, so no interrupt output.
// - Writing 1 enables a flag, writing 0 masks it.
// - Enable bit 9 gates the dual-role event flag.
// - Enable bit 8 gates the async list done flag.
// - Flags stay set after read; writing 1 clears a bit.
// - Async list done flag set on done-count or time-out threshold.
// - Clock resumed flag set when internal clock runs again after suspend.
module hcif_irq_flags
  import hcif_pkg::*;
#(
  parameter int NUM_FLAGS = 10
) (
  input  wire logic         REF_CLK_I,
  input  wire logic         RST_N_I,
  input  wire hcif_cmd_s    CMD_I,
  output logic [15:0]       RD_DATA_O,
  output logic              RD_VALID_O,
  input  wire logic [1:0]   HOST_CTRL_SUSPEND_I,
  input  wire logic         GLOBAL_INT_EN_I,
  input  wire logic         SOF_TICK_I,
  output logic              SOF_SEND_O,
  output logic              SUSPENDED_O,
  input  wire logic         OPR_EVENT_I,
  input  wire logic         XFER_COUNT_ZERO_I,
  input  wire logic         END_OF_TRANSFER_I,
  input  wire logic         ISO_ZERO_DONE_I,
  input  wire logic         ISO_ONE_DONE_I,
  input  wire logic         INTL_ACK_DONE_I,
  input  wire logic         ATL_COUNT_HIT_I,
  input  wire logic         ATL_TIMEOUT_HIT_I,
  input  wire logic         OTG_EVENT_I,
  input  wire logic         CLOCK_RUNNING_I,
  output logic              INT_O
);

  // --------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------
  logic                 rd_flags;
  logic                 wr_flags;
  logic                 rd_en;
  logic                 wr_en;
  hcif_pwr_e            pwr_q;
  hcif_pwr_e            pwr_d;
  logic                 eot_prev_q;
  logic                 clk_run_prev_q;
  logic [NUM_FLAGS-1:0] flags_q;
  logic [NUM_FLAGS-1:0] en_q;
  hcif_events_s         ev;
  logic                 susp_req;

  localparam logic [NUM_FLAGS-1:0] FLAGS_RST = `HCIF_FLAGS_RST;

  assign rd_flags = CMD_I.valid && (CMD_I.code == `HCIF_CMD_FLAGS_RD);
  assign wr_flags = CMD_I.valid && (CMD_I.code == `HCIF_CMD_FLAGS_WR);
  assign rd_en    = CMD_I.valid && (CMD_I.code == `HCIF_CMD_ENABLES_RD);
  assign wr_en    = CMD_I.valid && (CMD_I.code == `HCIF_CMD_ENABLES_WR);

  // --------------------------------------------------------------------
  // Suspend state
  // --------------------------------------------------------------------
  assign susp_req = (HOST_CTRL_SUSPEND_I == `HCIF_SUSP_REQ);

  always_comb begin
    case (pwr_q)
      HCIF_RUN:  pwr_d = susp_req ? HCIF_SUSP : HCIF_RUN;
      HCIF_SUSP: pwr_d = susp_req ? HCIF_SUSP : HCIF_RUN;
      default:   pwr_d = HCIF_RUN;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pwr_q <= HCIF_RUN;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  assign SUSPENDED_O = (pwr_q == HCIF_SUSP);

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SOF_SEND_O <= 1'b0;
    end else begin
      SOF_SEND_O <= SOF_TICK_I && (pwr_q == HCIF_RUN);
    end
  end

  // --------------------------------------------------------------------
  // Edge detectors for level inputs
  // --------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      eot_prev_q     <= 1'b0;
      // Clock taken as running out of reset, no false resume edge
      clk_run_prev_q <= 1'b1;
    end else begin
      eot_prev_q     <= END_OF_TRANSFER_I;
      clk_run_prev_q <= CLOCK_RUNNING_I;
    end
  end

  // --------------------------------------------------------------------
  // Event sources
  // --------------------------------------------------------------------
  always_comb begin
    ev.sof       = SOF_TICK_I && (pwr_q == HCIF_RUN);
    ev.iso_zero  = ISO_ZERO_DONE_I;
    ev.iso_one   = ISO_ONE_DONE_I;
    ev.xfer_done = XFER_COUNT_ZERO_I || (END_OF_TRANSFER_I && !eot_prev_q);
    ev.opr       = OPR_EVENT_I;
    ev.suspended = (pwr_q == HCIF_RUN) && susp_req;
    ev.clk_ready = CLOCK_RUNNING_I && !clk_run_prev_q;
    ev.intl      = INTL_ACK_DONE_I;
    ev.atl       = ATL_COUNT_HIT_I || ATL_TIMEOUT_HIT_I;
    ev.otg       = OTG_EVENT_I;
  end

  // --------------------------------------------------------------------
  // Sticky flags
  // --------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          flags_q[gi] <= FLAGS_RST[gi];
        end else if (ev[gi]) begin
          flags_q[gi] <= 1'b1;
        end else if (wr_flags && CMD_I.data[gi]) begin
          flags_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Enables
  // --------------------------------------------------------------------
  // cleared at power-on, write sets or masks
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      en_q <= `HCIF_ENABLES_RST;
    end else if (wr_en) begin
      en_q <= CMD_I.data[NUM_FLAGS-1:0];
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RD_DATA_O  <= `HCIF_RDATA_RST;
      RD_VALID_O <= 1'b0;
    end else begin
      RD_VALID_O <= rd_flags || rd_en;
      if (rd_flags) begin
        RD_DATA_O <= {{(16-NUM_FLAGS){1'b0}}, flags_q};
      end else if (rd_en) begin
        RD_DATA_O <= {{(16-NUM_FLAGS){1'b0}}, en_q};
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupt output
  // --------------------------------------------------------------------
  // per-bit gating, OR of gated bits, global enable, registered output
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      INT_O <= 1'b0;
    end else begin
      INT_O <= GLOBAL_INT_EN_I && |(flags_q & en_q);
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence s_susp_req;
    (pwr_q == HCIF_RUN) && susp_req;
  endsequence

  sequence s_susp_done;
    (pwr_q == HCIF_SUSP) && flags_q[`HCIF_BIT_SUSPENDED];
  endsequence

  sequence s_susp_held;
    (pwr_q == HCIF_SUSP) && susp_req && !flags_q[`HCIF_BIT_SUSPENDED];
  endsequence

  a_susp_entry_flag: assert property (s_susp_req |=> s_susp_done)
    else $error("suspend entry did not set state and flag");

  a_sof_suppressed: assert property ((pwr_q == HCIF_SUSP) |=> !SOF_SEND_O)
    else $error("frame start sent while suspended");

  a_sof_flag_set: assert property ((SOF_TICK_I && pwr_q == HCIF_RUN) |=> flags_q[0] && SOF_SEND_O)
    else $error("frame start did not set flag and send");

  a_xfer_done_set: assert property ((END_OF_TRANSFER_I && !eot_prev_q) |=> flags_q[3])
    else $error("end of transfer edge did not set flag");

  a_atl_done_set: assert property ((ATL_COUNT_HIT_I || ATL_TIMEOUT_HIT_I) |=> flags_q[8])
    else $error("async list threshold did not set flag");

  a_flag_sticky_read: assert property ((flags_q[4] && !(wr_flags && CMD_I.data[4])) |=> flags_q[4])
    else $error("operational flag cleared without write");

  a_flag_w1c_clear: assert property ((wr_flags && CMD_I.data[2] && !ISO_ONE_DONE_I) |=> !flags_q[2])
    else $error("write one did not clear flag");

  a_flags_read_data: assert property (rd_flags |=> RD_VALID_O && RD_DATA_O == {6'h00, $past(flags_q)})
    else $error("flag read returned wrong data");

  a_enable_write: assert property (wr_en ##1 rd_en |=> RD_DATA_O[9:0] == $past(CMD_I.data[9:0], 2))
    else $error("enable readback mismatch");

  a_irq_global_off: assert property (!GLOBAL_INT_EN_I |=> !INT_O)
    else $error("interrupt raised with global enable low");

  a_irq_otg_gate: assert property ((GLOBAL_INT_EN_I && flags_q[9] && en_q[9]) |=> INT_O)
    else $error("enabled dual-role flag did not raise interrupt");

  a_irq_masked: assert property ((en_q == 10'h000) |=> !INT_O)
    else $error("interrupt raised with all enables clear");

  a_susp_once: assert property (s_susp_held |=> !flags_q[5])
    else $error("suspended flag set again without new entry");

  a_susp_exit: assert property ((pwr_q == HCIF_SUSP && !susp_req) |=> !SUSPENDED_O)
    else $error("suspend not left after request dropped");

  a_sof_flag_held: assert property ((pwr_q == HCIF_SUSP && !flags_q[0]) |=> !flags_q[0])
    else $error("frame start flag set while suspended");

  a_opr_flag_set: assert property (OPR_EVENT_I |=> flags_q[4])
    else $error("operational event did not set flag");

  a_xfer_count_set: assert property (XFER_COUNT_ZERO_I |=> flags_q[3])
    else $error("transfer count zero did not set flag");

  a_iso_one_set: assert property (ISO_ONE_DONE_I |=> flags_q[2])
    else $error("iso buffer one done did not set flag");

  a_iso_zero_set: assert property (ISO_ZERO_DONE_I |=> flags_q[1])
    else $error("iso buffer zero done did not set flag");

  a_code_quiet: assert property ((CMD_I.valid && !rd_flags && !rd_en) |=> !RD_VALID_O)
    else $error("read answer for a non-read code");

  a_en_read: assert property (rd_en |=> RD_VALID_O && RD_DATA_O == {6'h00, $past(en_q)})
    else $error("enable read returned wrong data");

  a_irq_unmatched: assert property ((|flags_q && (flags_q & en_q) == 10'h000) |=> !INT_O)
    else $error("interrupt raised by a flag without its enable");

  a_enable_store: assert property (wr_en |=> en_q == $past(CMD_I.data[NUM_FLAGS-1:0]))
    else $error("enable write not stored");

  a_enable_hold: assert property (!wr_en |=> en_q == $past(en_q))
    else $error("enables changed without write");

  a_irq_atl_gate: assert property ((GLOBAL_INT_EN_I && flags_q[8] && en_q[8]) |=> INT_O)
    else $error("enabled async list flag did not raise interrupt");

  a_set_wins: assert property ((OPR_EVENT_I && wr_flags && CMD_I.data[4]) |=> flags_q[4])
    else $error("clear beat a same-cycle event");

  a_clk_ready_set: assert property ((CLOCK_RUNNING_I && !clk_run_prev_q) |=> flags_q[6])
    else $error("clock resume did not set flag");

  a_irq_any_on: assert property ((GLOBAL_INT_EN_I && |(flags_q & en_q)) |=> INT_O)
    else $error("enabled flag did not raise interrupt");

endmodule

/* src/hcif_pkg.sv */
package hcif_pkg;

  // --------------------------------------------------------------------
  // Event vector, bit order matches the flag register
  // --------------------------------------------------------------------
  typedef struct packed {
    logic otg;
    logic atl;
    logic intl;
    logic clk_ready;
    logic suspended;
    logic opr;
    logic xfer_done;
    logic iso_one;
    logic iso_zero;
    logic sof;
  } hcif_events_s;

  // --------------------------------------------------------------------
  // Command port word
  // --------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [7:0]  code;
    logic [15:0] data;
  } hcif_cmd_s;

  // --------------------------------------------------------------------
  // Power state
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    HCIF_RUN  = 2'b01,
    HCIF_SUSP = 2'b10
  } hcif_pwr_e;

endpackage

/* tb/hcif_cpu_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Processor side of the command port
// ----------------------------------------------------------------------
module hcif_cpu_model
  import hcif_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic [15:0] rd_data_i,
  input  wire logic        rd_valid_i,
  output hcif_cmd_s        cmd_o
);
  initial cmd_o = '0;

  task automatic issue(input logic [7:0] code, input logic [15:0] data);
    @(negedge clk_i);
    cmd_o = '{valid: 1'b1, code: code, data: data};
    @(negedge clk_i);
    cmd_o = '{valid: 1'b0, code: ~code, data: ~data};
  endtask

  // No buffer fetch, DMA or cause read here
  task automatic read(input logic [7:0] code, output logic [15:0] val, output logic ok);
    issue(code, 16'h0000);
    ok  = rd_valid_i;
    val = rd_data_i;
  endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ns
`include "hcif_consts.svh"
module tb;
  import hcif_pkg::*;
  logic        clk       = 1'b0;
  logic        rst_n     = 1'b0;
  logic        glob_en   = 1'b0;
  logic [1:0]  hold_susp = 2'h0;
  logic [11:0] ev        = 12'h000;
  hcif_cmd_s   cmd;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic        sof_send;
  logic        suspended;
  logic        int_out;
  logic [15:0] val;
  logic [15:0] m;
  logic        ok;
  int          fail_count = 0;
  int          compares   = 0;
  int          bit_of [12] = '{0, 1, 2, 3, 3, 4, 5, 6, 7, 8, 8, 9};

  always #5 clk = ~clk;

  hcif_cpu_model cpu (.clk_i(clk), .rd_data_i(rd_data), .rd_valid_i(rd_valid), .cmd_o(cmd));

  hcif_irq_flags dut (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .CMD_I(cmd), .RD_DATA_O(rd_data),
    .RD_VALID_O(rd_valid), .HOST_CTRL_SUSPEND_I(hold_susp | {2{ev[6]}}),
    .GLOBAL_INT_EN_I(glob_en), .SOF_TICK_I(ev[0]), .SOF_SEND_O(sof_send),
    .SUSPENDED_O(suspended), .OPR_EVENT_I(ev[5]), .XFER_COUNT_ZERO_I(ev[3]),
    .END_OF_TRANSFER_I(ev[4]), .ISO_ZERO_DONE_I(ev[1]), .ISO_ONE_DONE_I(ev[2]),
    .INTL_ACK_DONE_I(ev[8]), .ATL_COUNT_HIT_I(ev[9]), .ATL_TIMEOUT_HIT_I(ev[10]),
    .OTG_EVENT_I(ev[11]), .CLOCK_RUNNING_I(ev[7]), .INT_O(int_out)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    check({15'h0000, seen}, {15'h0000, exp});
  endtask

  task automatic results;
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    cpu.read(code, val, ok);
    chk1(ok, 1'b1);
    check(val, exp);
  endtask

  task automatic pulse(input logic [11:0] v);
    @(negedge clk);
    ev = v;
    @(negedge clk);
    ev = 12'h000;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    results();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    cycles(3);
    rst_n = 1'b1;
    rd(`HCIF_CMD_ENABLES_RD, 16'h0000);
    rd(`HCIF_CMD_FLAGS_RD, 16'h0000);
    chk1(int_out, 1'b0);
    cpu.issue(`HCIF_CMD_ENABLES_WR, 16'hFFFF);
    rd(`HCIF_CMD_ENABLES_RD, 16'h03FF);
    cpu.issue(8'h26, 16'h0000);
    chk1(rd_valid, 1'b0);
    cpu.issue(8'hA6, 16'h0000);
    rd(`HCIF_CMD_ENABLES_RD, 16'h03FF);
    cpu.issue(`HCIF_CMD_ENABLES_WR, 16'h0000);
    rd(`HCIF_CMD_ENABLES_RD, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      m = 16'h0001 << bit_of[i];
      pulse(12'h001 << i);
      rd(`HCIF_CMD_FLAGS_RD, m);
      rd(`HCIF_CMD_FLAGS_RD, m);
      glob_en = 1'b1;
      cpu.issue(`HCIF_CMD_ENABLES_WR, ~m & 16'h03FF);
      cycles(2);
      chk1(int_out, 1'b0);
      cpu.issue(`HCIF_CMD_ENABLES_WR, m);
      cycles(2);
      chk1(int_out, 1'b1);
      glob_en = 1'b0;
      cycles(2);
      chk1(int_out, 1'b0);
      cpu.issue(`HCIF_CMD_FLAGS_WR, ~m);
      rd(`HCIF_CMD_FLAGS_RD, m);
      cpu.issue(`HCIF_CMD_FLAGS_WR, m);
      rd(`HCIF_CMD_FLAGS_RD, 16'h0000);
    end
    hold_susp = `HCIF_SUSP_REQ;
    cycles(2);
    chk1(suspended, 1'b1);
    ev = 12'h001;
    cycles(1);
    chk1(sof_send, 1'b0);
    ev = 12'h000;
    rd(`HCIF_CMD_FLAGS_RD, 16'h0020);
    cpu.issue(`HCIF_CMD_FLAGS_WR, 16'h0020);
    rd(`HCIF_CMD_FLAGS_RD, 16'h0000);
    chk1(suspended, 1'b1);
    hold_susp = 2'h0;
    cpu.issue(`HCIF_CMD_FLAGS_WR, 16'h03FF);
    chk1(suspended, 1'b0);
    ev = 12'h001;
    cycles(1);
    chk1(sof_send, 1'b1);
    ev = 12'h000;
    cycles(1);
    chk1(sof_send, 1'b0);
    rd(`HCIF_CMD_FLAGS_RD, 16'h0001);
    fork
      pulse(12'h020);
      cpu.issue(`HCIF_CMD_FLAGS_WR, 16'h0010);
    join
    rd(`HCIF_CMD_FLAGS_RD, 16'h0011);
    results();
  end
endmodule
